// File: rtl/fpgio_regs.vh
/*
 Register addresses, reset values, bit positions and pin masks of the
 four-port general-purpose I/O block. Included by the top module and the testbench.
*/
`ifndef FPGIO_REGS_VH
`define FPGIO_REGS_VH

// Register addresses on the 4-bit register port
`define FPGIO_ADDR_PA_DATA 4'h0
`define FPGIO_ADDR_PA_DIR 4'h1
`define FPGIO_ADDR_PB_DATA 4'h2
`define FPGIO_ADDR_PB_DIR 4'h3
`define FPGIO_ADDR_PC_DATA 4'h4
`define FPGIO_ADDR_PC_DIR 4'h5
`define FPGIO_ADDR_PD_DATA 4'h6
`define FPGIO_ADDR_PD_DIR 4'h7
`define FPGIO_ADDR_IRQ_EN 4'h8
`define FPGIO_ADDR_MISC 4'h9

// Reset values
`define FPGIO_RST_BYTE 8'h00
`define FPGIO_RST_PC 3'h0
`define FPGIO_RST_MISC 2'h0
`define FPGIO_RD_UNMAPPED 8'h00

// Port C: three implemented bits, the rest read as ones
`define FPGIO_PC_BITS 3
`define FPGIO_PC_ONES 5'h1F

// Miscellaneous register bit positions
`define FPGIO_MISC_CLKOUT 0
`define FPGIO_MISC_USB 1

// Pin attribute masks
`define FPGIO_PA_PULLUP 8'hF9
`define FPGIO_PA_OPEN_DRAIN 8'h06
`define FPGIO_PD_PULLUP 8'hF0
`define FPGIO_PC_PULLUP 3'h7
`define FPGIO_IRQ_RISING 8'h33

// Pin positions
`define FPGIO_PA_CLK 0
`define FPGIO_PA_SDA 1
`define FPGIO_PA_SCL 2
`define FPGIO_PA_TCLK 3
`define FPGIO_PA_CAP1 4
`define FPGIO_PA_CAP2 5
`define FPGIO_PA_CMP1 6
`define FPGIO_PA_CMP2 7
`define FPGIO_PB_USB 1
`define FPGIO_PC_RX 0
`define FPGIO_PC_TX 1
`define FPGIO_PC_USB 2

// Analog channel codes
`define FPGIO_ADC_PD_BASE 4'h8
`define FPGIO_ADC_PD_LAST 4'hB

`endif

// File: rtl/fpgio_sync.v
/*
 Two-flop synchroniser, eight bits wide, for pin levels.
 Assumes the inputs are asynchronous to clk; the first stage is read only
 by the second.
*/
`timescale 1ns/1ps
module fpgio_sync (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    input wire ce,
    // Levels
    input wire [7:0] d,
    output reg [7:0] q
);
    reg [7:0] meta;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 8'h00;
            q <= 8'h00;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // fpgio_sync

// File: rtl/fpgio_edge.v
/*
 Edge detector for the eight external interrupt inputs.
 Assumes synchronised levels. Bits set in RISING_MASK react to a rising
 edge, the others to a falling edge. Output is combinational, one cycle.
*/
`timescale 1ns/1ps
module fpgio_edge #(
    parameter [7:0] RISING_MASK = 8'h00
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    input wire ce,
    // Levels and gating
    input wire [7:0] level,
    input wire [7:0] enable,
    output wire [7:0] event_hit
);
    reg [7:0] prev;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= 8'h00;
        end else if (ce) begin
            prev <= level;
        end
    end

    // Both edges computed, polarity picked per bit
    assign event_hit = enable & {8{ce}} &
        ((RISING_MASK & level & ~prev) | (~RISING_MASK & ~level & prev));
endmodule // fpgio_edge

// File: rtl/fpgio_top.v
/*
 Four-port general-purpose I/O block with fixed alternate functions.
 Holds the data and direction registers, pin muxing, pull-up control,
 analog switch select and the external interrupt edge requests.
 Assumes the timer, converter, I2C, serial and USB blocks drive their
 enables and signals from clk; pins are asynchronous. Each pin is split
 into input, output and active-low output enable; the pad adds pull-ups.
*/
`timescale 1ns/1ps
`include "fpgio_regs.vh"
module fpgio_top #(
    parameter SMALL_PACKAGE = 0
) (
    // Clock, reset, enable
    input wire clk,
    input wire arst_n,
    input wire ce,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Port A pins
    input wire [7:0] pa_in,
    output reg [7:0] pa_out,
    output reg [7:0] pa_oe_n,
    output reg [7:0] pa_pullup,
    // Port B pins
    input wire [7:0] pb_in,
    output reg [7:0] pb_out,
    output reg [7:0] pb_oe_n,
    // Port C pins
    input wire [2:0] pc_in,
    output reg [2:0] pc_out,
    output reg [2:0] pc_oe_n,
    output reg [2:0] pc_pullup,
    // Port D pins
    input wire [7:0] pd_in,
    output reg [7:0] pd_out,
    output reg [7:0] pd_oe_n,
    output reg [7:0] pd_pullup,
    // Timer
    input wire timer_clock_sel_hi,
    input wire timer_clock_sel_lo,
    input wire compare_one_pin_enable,
    input wire compare_two_pin_enable,
    input wire compare_output_one,
    input wire compare_output_two,
    output reg timer_external_clock_in,
    output reg capture_input_one,
    output reg capture_input_two,
    // I2C
    input wire i2c_enable,
    input wire i2c_sda_drive,
    input wire i2c_scl_drive,
    output reg i2c_sda_in,
    output reg i2c_scl_in,
    // Serial interface
    input wire serial_enable,
    input wire serial_transmit_out,
    output reg serial_receive_in,
    // USB
    input wire usb_transmit_enable_out,
    // Converter
    input wire [3:0] analog_channel_select,
    output reg [7:0] analog_switch_b,
    output reg [3:0] analog_switch_d,
    // Interrupt requests, one per vector
    output reg irq_port_a,
    output reg irq_port_b
);
    reg [7:0] pa_latch;
    reg [7:0] pa_dir;
    reg [7:0] pb_latch;
    reg [7:0] pb_dir;
    reg [2:0] pc_latch;
    reg [2:0] pc_dir;
    reg [7:0] pd_latch;
    reg [7:0] pd_dir;
    reg [7:0] ext_irq_enable_register;
    reg [1:0] misc_control_register;
    reg clk_half;

    wire [7:0] pa_sync;
    wire [7:0] pb_sync;
    wire [7:0] pcd_sync;
    wire [7:0] pd_sync;
    wire [7:0] irq_hit;
    wire [7:0] irq_level;
    wire [7:0] irq_gate;
    wire clock_output_select;
    wire usb_select;

    reg [7:0] next_pa_out;
    reg [7:0] next_pa_oe_n;
    reg [7:0] next_pb_out;
    reg [7:0] next_pb_oe_n;
    reg [2:0] next_pc_out;
    reg [2:0] next_pc_oe_n;
    reg [7:0] next_pa_dir_eff;
    reg [7:0] next_rdata;

    assign clock_output_select = misc_control_register[`FPGIO_MISC_CLKOUT];
    assign usb_select = misc_control_register[`FPGIO_MISC_USB];

    // Read value per bit: latch for outputs, pin for inputs and open drain
    function [7:0] port_read;
        input [7:0] latch;
        input [7:0] dir;
        input [7:0] pin;
        input [7:0] od;
        begin
            port_read = (latch & dir & ~od) | (pin & ~(dir & ~od));
        end
    endfunction

    // Input pull-up only where the pin has one and is an input
    function [7:0] pullup_of;
        input [7:0] mask;
        input [7:0] dir;
        begin
            pullup_of = mask & ~dir;
        end
    endfunction
    // Port C read and pull-up worked at byte width, then cut to its three pins
    wire [7:0] pc_read_full = port_read({5'h00, pc_latch}, {5'h00, pc_dir}, pcd_sync,
        `FPGIO_RST_BYTE);
    wire [7:0] pc_pull_full = pullup_of({5'h00, `FPGIO_PC_PULLUP}, {5'h00, ~next_pc_oe_n});

    fpgio_sync u_sync_a (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(pa_in),
        .q(pa_sync)
    );

    fpgio_sync u_sync_b (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(pb_in),
        .q(pb_sync)
    );

    fpgio_sync u_sync_c (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .d({5'h00, pc_in}),
        .q(pcd_sync)
    );

    fpgio_sync u_sync_d (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(pd_in),
        .q(pd_sync)
    );

    // Interrupt inputs: IT1..IT4 on A4..A7, IT5..IT8 on B4..B7
    assign irq_level = {pb_sync[7:4], pa_sync[7:4]};
    // Pins configured as outputs never raise a request
    assign irq_gate = ext_irq_enable_register &
        ~{pb_dir[7:4], next_pa_dir_eff[7:4]};

    fpgio_edge #(
        .RISING_MASK(`FPGIO_IRQ_RISING)
    ) u_edge (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .level(irq_level),
        .enable(irq_gate),
        .event_hit(irq_hit)
    );

    // Register writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_latch <= `FPGIO_RST_BYTE;
            pa_dir <= `FPGIO_RST_BYTE;
            pb_latch <= `FPGIO_RST_BYTE;
            pb_dir <= `FPGIO_RST_BYTE;
            pc_latch <= `FPGIO_RST_PC;
            pc_dir <= `FPGIO_RST_PC;
            pd_latch <= `FPGIO_RST_BYTE;
            pd_dir <= `FPGIO_RST_BYTE;
            ext_irq_enable_register <= `FPGIO_RST_BYTE;
            misc_control_register <= `FPGIO_RST_MISC;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `FPGIO_ADDR_PA_DATA: pa_latch <= reg_wdata;
                `FPGIO_ADDR_PA_DIR: pa_dir <= reg_wdata;
                `FPGIO_ADDR_PB_DATA: pb_latch <= reg_wdata;
                `FPGIO_ADDR_PB_DIR: pb_dir <= reg_wdata;
                `FPGIO_ADDR_PC_DATA: pc_latch <= reg_wdata[`FPGIO_PC_BITS-1:0];
                `FPGIO_ADDR_PC_DIR: pc_dir <= reg_wdata[`FPGIO_PC_BITS-1:0];
                `FPGIO_ADDR_PD_DATA: pd_latch <= reg_wdata;
                `FPGIO_ADDR_PD_DIR: pd_dir <= reg_wdata;
                `FPGIO_ADDR_IRQ_EN: ext_irq_enable_register <= reg_wdata;
                `FPGIO_ADDR_MISC: misc_control_register <=
                    reg_wdata[`FPGIO_MISC_USB:`FPGIO_MISC_CLKOUT];
                default: ;
            endcase
        end
    end

    // Pin drive and alternate-function override
    always @* begin
        next_pa_dir_eff = pa_dir;
        next_pa_out = pa_latch & pa_dir;
        next_pa_oe_n = ~pa_dir;
        // Open-drain pins: drive low only, released otherwise
        next_pa_out[`FPGIO_PA_SDA] = 1'b0;
        next_pa_out[`FPGIO_PA_SCL] = 1'b0;
        if (i2c_enable) begin
            next_pa_oe_n[`FPGIO_PA_SDA] = i2c_sda_drive;
            next_pa_oe_n[`FPGIO_PA_SCL] = i2c_scl_drive;
            next_pa_dir_eff[`FPGIO_PA_SDA] = 1'b1;
            next_pa_dir_eff[`FPGIO_PA_SCL] = 1'b1;
        end else begin
            next_pa_oe_n[`FPGIO_PA_SDA] =
                ~(pa_dir[`FPGIO_PA_SDA] & ~pa_latch[`FPGIO_PA_SDA]);
            next_pa_oe_n[`FPGIO_PA_SCL] =
                ~(pa_dir[`FPGIO_PA_SCL] & ~pa_latch[`FPGIO_PA_SCL]);
        end
        if (clock_output_select) begin
            next_pa_out[`FPGIO_PA_CLK] = ~clk_half;
            next_pa_oe_n[`FPGIO_PA_CLK] = 1'b0;
            next_pa_dir_eff[`FPGIO_PA_CLK] = 1'b1;
        end
        if (compare_one_pin_enable) begin
            next_pa_out[`FPGIO_PA_CMP1] = compare_output_one;
            next_pa_oe_n[`FPGIO_PA_CMP1] = 1'b0;
            next_pa_dir_eff[`FPGIO_PA_CMP1] = 1'b1;
        end
        if (compare_two_pin_enable) begin
            next_pa_out[`FPGIO_PA_CMP2] = compare_output_two;
            next_pa_oe_n[`FPGIO_PA_CMP2] = 1'b0;
            next_pa_dir_eff[`FPGIO_PA_CMP2] = 1'b1;
        end

        next_pb_out = pb_latch & pb_dir;
        next_pb_oe_n = ~pb_dir;
        if (usb_select && SMALL_PACKAGE != 0) begin
            next_pb_out[`FPGIO_PB_USB] = usb_transmit_enable_out;
            next_pb_oe_n[`FPGIO_PB_USB] = 1'b0;
        end

        next_pc_out = pc_latch & pc_dir;
        next_pc_oe_n = ~pc_dir;
        if (serial_enable) begin
            next_pc_out[`FPGIO_PC_TX] = serial_transmit_out;
            next_pc_oe_n[`FPGIO_PC_TX] = 1'b0;
        end
        if (usb_select && SMALL_PACKAGE == 0) begin
            next_pc_out[`FPGIO_PC_USB] = usb_transmit_enable_out;
            next_pc_oe_n[`FPGIO_PC_USB] = 1'b0;
        end
    end

    // Read mux; open-drain pins of port A read the pin in output mode too
    always @* begin
        case (reg_addr)
            `FPGIO_ADDR_PA_DATA: next_rdata = port_read(pa_latch, pa_dir, pa_sync,
                `FPGIO_PA_OPEN_DRAIN);
            `FPGIO_ADDR_PA_DIR: next_rdata = pa_dir;
            `FPGIO_ADDR_PB_DATA: next_rdata = port_read(pb_latch, pb_dir, pb_sync,
                `FPGIO_RST_BYTE);
            `FPGIO_ADDR_PB_DIR: next_rdata = pb_dir;
            `FPGIO_ADDR_PC_DATA: next_rdata = {`FPGIO_PC_ONES,
                pc_read_full[`FPGIO_PC_BITS-1:0]};
            `FPGIO_ADDR_PC_DIR: next_rdata = {`FPGIO_PC_ONES, pc_dir};
            `FPGIO_ADDR_PD_DATA: next_rdata = port_read(pd_latch, pd_dir, pd_sync,
                `FPGIO_RST_BYTE);
            `FPGIO_ADDR_PD_DIR: next_rdata = pd_dir;
            `FPGIO_ADDR_IRQ_EN: next_rdata = ext_irq_enable_register;
            `FPGIO_ADDR_MISC: next_rdata = {6'h00, misc_control_register};
            default: next_rdata = `FPGIO_RD_UNMAPPED;
        endcase
    end

    // All outputs registered; pins therefore lag the registers by one cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `FPGIO_RST_BYTE;
            clk_half <= 1'b0;
            pa_out <= `FPGIO_RST_BYTE;
            pa_oe_n <= ~`FPGIO_RST_BYTE;
            pa_pullup <= `FPGIO_PA_PULLUP;
            pb_out <= `FPGIO_RST_BYTE;
            pb_oe_n <= ~`FPGIO_RST_BYTE;
            pc_out <= `FPGIO_RST_PC;
            pc_oe_n <= ~`FPGIO_RST_PC;
            pc_pullup <= `FPGIO_PC_PULLUP;
            pd_out <= `FPGIO_RST_BYTE;
            pd_oe_n <= ~`FPGIO_RST_BYTE;
            pd_pullup <= `FPGIO_PD_PULLUP;
            timer_external_clock_in <= 1'b0;
            capture_input_one <= 1'b0;
            capture_input_two <= 1'b0;
            i2c_sda_in <= 1'b1;
            i2c_scl_in <= 1'b1;
            serial_receive_in <= 1'b1;
            analog_switch_b <= `FPGIO_RST_BYTE;
            analog_switch_d <= 4'h0;
            irq_port_a <= 1'b0;
            irq_port_b <= 1'b0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? next_rdata : `FPGIO_RD_UNMAPPED;
            // A flop cannot pass clk itself, so the pin carries clk / 2
            clk_half <= clock_output_select ? ~clk_half : 1'b0;
            pa_out <= next_pa_out;
            pa_oe_n <= next_pa_oe_n;
            pa_pullup <= pullup_of(`FPGIO_PA_PULLUP, next_pa_dir_eff);
            pb_out <= next_pb_out;
            pb_oe_n <= next_pb_oe_n;
            pc_out <= next_pc_out;
            pc_oe_n <= next_pc_oe_n;
            pc_pullup <= pc_pull_full[`FPGIO_PC_BITS-1:0];
            pd_out <= pd_latch & pd_dir;
            pd_oe_n <= ~pd_dir;
            pd_pullup <= pullup_of(`FPGIO_PD_PULLUP, pd_dir);
            timer_external_clock_in <= timer_clock_sel_hi & timer_clock_sel_lo &
                pa_sync[`FPGIO_PA_TCLK];
            capture_input_one <= pa_sync[`FPGIO_PA_CAP1];
            capture_input_two <= pa_sync[`FPGIO_PA_CAP2];
            i2c_sda_in <= pa_sync[`FPGIO_PA_SDA];
            i2c_scl_in <= pa_sync[`FPGIO_PA_SCL];
            serial_receive_in <= serial_enable ? pcd_sync[`FPGIO_PC_RX] : 1'b1;
            analog_switch_b <= (analog_channel_select[3] == 1'b0) ?
                (8'h01 << analog_channel_select[2:0]) : 8'h00;
            analog_switch_d <= (analog_channel_select >= `FPGIO_ADC_PD_BASE &&
                analog_channel_select <= `FPGIO_ADC_PD_LAST) ?
                (4'h1 << analog_channel_select[1:0]) : 4'h0;
            irq_port_a <= |irq_hit[3:0];
            irq_port_b <= |irq_hit[7:4];
        end
    end
endmodule // fpgio_top

// File: dv/fpgio_monitor.sv
/* Checker for the four-port I/O block: register port, pin drive, analog
   select and interrupt cause. Assumes binding to fpgio_top with ce high. */
`timescale 1ns/1ps
module fpgio_monitor (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Pins and alternate functions
    input wire [7:0] pa_in,
    input wire [7:0] pa_out,
    input wire [7:0] pa_pullup,
    input wire [7:0] pb_out,
    input wire [7:0] pb_oe_n,
    input wire [7:0] pd_oe_n,
    input wire [7:0] pd_pullup,
    input wire [3:0] analog_channel_select,
    input wire [7:0] analog_switch_b,
    input wire [3:0] analog_switch_d,
    input wire irq_port_a
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    reg [7:0] pa_prev;
    reg [5:0] pa_hist;
    // Loose window: any pin change in the last six edges may explain a request
    always @(posedge clk) begin
        pa_prev <= pa_in;
        pa_hist <= {pa_hist[4:0], pa_in != pa_prev};
    end
    sequence s_pbdir_wr; reg_wr && reg_addr == 4'h3; endsequence
    sequence s_pbdat_wr; reg_wr && reg_addr == 4'h2; endsequence
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; reg_rd && reg_addr >= 4'hA |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_pc_upper;
        reg_rd && (reg_addr == 4'h4 || reg_addr == 4'h5) |=> reg_rdata[7:3] == 5'h1F;
    endproperty
    a_pc_upper: assert property (p_pc_upper) else $error("port C upper bits");
    property p_dir_drive; s_pbdir_wr |=> ##1 pb_oe_n == ~$past(reg_wdata, 2); endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("direction drive");
    property p_latch;
        s_pbdat_wr |=> ##1 (pb_out & ~pb_oe_n) == ($past(reg_wdata, 2) & ~pb_oe_n);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not on pins");
    property p_irq_cause; irq_port_a |-> |pa_hist; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without edge");
    property p_open_drain; pa_out[2:1] == 2'b00 && pa_pullup[2:1] == 2'b00; endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain pins");
    property p_pd_pullup; pd_pullup == {pd_oe_n[7:4], 4'h0}; endproperty
    a_pd_pullup: assert property (p_pd_pullup) else $error("port D pull-ups");
    property p_adc_b;
        $past(arst_n) && $stable(analog_channel_select) && analog_channel_select < 4'h8
            |-> analog_switch_b == (8'h01 << analog_channel_select) && analog_switch_d == 4'h0;
    endproperty
    a_adc_b: assert property (p_adc_b) else $error("analog select B");
    property p_adc_d;
        $past(arst_n) && $stable(analog_channel_select) && analog_channel_select >= 4'h8
            && analog_channel_select <= 4'hB |-> analog_switch_b == 8'h00
            && analog_switch_d == (4'h1 << (analog_channel_select - 4'h8));
    endproperty
    a_adc_d: assert property (p_adc_d) else $error("analog select D");
endmodule // fpgio_monitor

bind fpgio_top fpgio_monitor u_monitor (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pa_in, .pa_out,
    .pa_pullup, .pb_out, .pb_oe_n, .pd_oe_n, .pd_pullup, .analog_channel_select,
    .analog_switch_b, .analog_switch_d, .irq_port_a
);

// File: dv/fpgio_pad.sv
/* Board model of one port: resolves each pad from the block's drive, an
   external driver and the pull-up. Assumes clk runs all the time. */
`timescale 1ns/1ps
module fpgio_pad #(
    parameter W = 8
) (
    // Clock
    input wire clk,
    // Block side
    input wire [W-1:0] out,
    input wire [W-1:0] oe_n,
    input wire [W-1:0] pull_on,
    // Board side
    input wire [W-1:0] ext,
    input wire [W-1:0] ext_en,
    output reg [W-1:0] pin
);
    reg [W-1:0] drift = {W{1'b0}};
    integer i;
    // A floating pad must not pass for a steady level
    always @(posedge clk) begin
        drift <= ~drift;
    end
    always @* begin
        for (i = 0; i < W; i = i + 1) begin
            if (!oe_n[i]) begin
                pin[i] = out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext[i];
            end else begin
                pin[i] = pull_on[i] | drift[i];
            end
        end
    end
endmodule // fpgio_pad

// File: dv/tb_fpgio_top.sv
/* Self-checking bench for the four-port I/O block: register map, pin drive
   and readback, alternate functions and edge interrupts.
   Assumes the board model fpgio_pad and the bound checker. */
`timescale 1ns/1ps
`include "fpgio_regs.vh"
module tb_fpgio_top;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg ce = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg rd_d = 1'b0;
    // Peripheral controls: sel hi, sel lo, cmp en 1/2, cmp 1/2, i2c, sda, scl, sci, tx, usb
    reg [11:0] ctl = 12'h180;
    reg [3:0] adc_sel = 4'h0;
    reg [7:0] pa_ext = 8'h00, pa_en = 8'h06, pb_ext = 8'h00, pd_ext = 8'h00;
    reg [2:0] pc_ext = 3'b101;
    wire [7:0] reg_rdata, pa_in, pa_out, pa_oe_n, pa_pullup, pb_in, pb_out, pb_oe_n;
    wire [2:0] pc_in, pc_out, pc_oe_n, pc_pullup;
    wire [7:0] pd_in, pd_out, pd_oe_n, pd_pullup, analog_switch_b;
    wire [3:0] analog_switch_d;
    wire timer_external_clock_in, capture_input_one, capture_input_two, i2c_sda_in;
    wire i2c_scl_in, serial_receive_in, irq_port_a, irq_port_b;
    int num_errors = 0;
    int compares = 0;
    int na, nb, i, k;
    logic [7:0] exp_q[$];
    logic [7:0] v, m, w;
    reg [31:0] seed = 32'h00016696;
    logic [7:0] rst_tab [0:15] = '{8'hF9, 8'h00, 8'h00, 8'h00, 8'hFD, 8'hF8, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    fpgio_top u_dut (
        .clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pa_in, .pa_out, .pa_oe_n, .pa_pullup, .pb_in, .pb_out, .pb_oe_n,
        .pc_in, .pc_out, .pc_oe_n, .pc_pullup, .pd_in, .pd_out, .pd_oe_n, .pd_pullup,
        .timer_clock_sel_hi(ctl[0]), .timer_clock_sel_lo(ctl[1]),
        .compare_one_pin_enable(ctl[2]), .compare_two_pin_enable(ctl[3]),
        .compare_output_one(ctl[4]), .compare_output_two(ctl[5]),
        .timer_external_clock_in, .capture_input_one, .capture_input_two,
        .i2c_enable(ctl[6]), .i2c_sda_drive(ctl[7]), .i2c_scl_drive(ctl[8]), .i2c_sda_in,
        .i2c_scl_in, .serial_enable(ctl[9]), .serial_transmit_out(ctl[10]),
        .serial_receive_in, .usb_transmit_enable_out(ctl[11]),
        .analog_channel_select(adc_sel), .analog_switch_b, .analog_switch_d,
        .irq_port_a, .irq_port_b
    );
    fpgio_pad #(.W(8)) u_pad_a (.clk, .out(pa_out), .oe_n(pa_oe_n), .pull_on(pa_pullup),
        .ext(pa_ext), .ext_en(pa_en), .pin(pa_in));
    fpgio_pad #(.W(8)) u_pad_b (.clk, .out(pb_out), .oe_n(pb_oe_n), .pull_on(8'h00),
        .ext(pb_ext), .ext_en(8'hFF), .pin(pb_in));
    fpgio_pad #(.W(3)) u_pad_c (.clk, .out(pc_out), .oe_n(pc_oe_n), .pull_on(pc_pullup),
        .ext(pc_ext), .ext_en(3'h7), .pin(pc_in));
    fpgio_pad #(.W(8)) u_pad_d (.clk, .out(pd_out), .oe_n(pd_oe_n), .pull_on(pd_pullup),
        .ext(pd_ext), .ext_en(8'hFF), .pin(pd_in));

    always #12.5 clk = ~clk;

    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        compares++;
        if (seen !== expd) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic wr(input [3:0] a, input [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [3:0] a, input [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic irqs();
        na = 0;
        nb = 0;
        repeat (8) begin
            @(posedge clk);
            #1;
            na += (irq_port_a === 1'b1);
            nb += (irq_port_b === 1'b1);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Read data is valid only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= reg_rd;
    end
    always @(negedge clk) begin
        if (rd_d && exp_q.size() > 0) begin
            check(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        #(25 * 5000);
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        settle(3);
        check(pa_pullup, 8'hF9);
        check(pd_pullup, 8'hF0);
        check(pa_oe_n, 8'hFF);
        for (i = 0; i < 16; i++) rd(i[3:0], rst_tab[i]);
        pa_en <= 8'hFF;
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            {w, m, v} = seed[23:0];
            pb_ext <= w;
            pd_ext <= w;
            wr(i[0] ? 4'h6 : 4'h2, v);
            wr(i[0] ? 4'h7 : 4'h3, m);
            settle(3);
            check(i[0] ? pd_oe_n : pb_oe_n, ~m);
            rd(i[0] ? 4'h6 : 4'h2, (v & m) | (w & ~m));
            rd(i[0] ? 4'h7 : 4'h3, m);
        end
        wr(`FPGIO_ADDR_PC_DATA, 8'hFF);
        wr(`FPGIO_ADDR_PC_DIR, 8'hFF);
        rd(`FPGIO_ADDR_PC_DATA, 8'hFF);
        wr(`FPGIO_ADDR_PC_DIR, 8'h08);
        rd(`FPGIO_ADDR_PC_DIR, 8'hF8);
        rd(`FPGIO_ADDR_PC_DATA, 8'hFD);
        wr(`FPGIO_ADDR_PA_DIR, 8'h02);
        wr(`FPGIO_ADDR_PA_DATA, 8'h02);
        settle(3);
        rd(`FPGIO_ADDR_PA_DATA, 8'h00);
        wr(`FPGIO_ADDR_PA_DATA, 8'h00);
        settle(1);
        check(pa_oe_n, 8'hFD);
        wr(`FPGIO_ADDR_PA_DIR, 8'h00);
        // Every interrupt input: wrong edge first on the falling-edge inputs, then the sensitive one
        wr(`FPGIO_ADDR_PB_DIR, 8'h00);
        wr(`FPGIO_ADDR_IRQ_EN, 8'hFF);
        pb_ext <= 8'h00;
        settle(4);
        for (k = 0; k < 8; k++) begin
            for (i = 0; i < 2; i++) begin
                @(posedge clk);
                if (k < 4) pa_ext[k + 4] <= (i == 1) ~^ `FPGIO_IRQ_RISING >> k;
                else pb_ext[k] <= (i == 1) ~^ `FPGIO_IRQ_RISING >> k;
                irqs();
                check(8'(na), 8'(i == 1 && k < 4));
                check(8'(nb), 8'(i == 1 && k >= 4));
            end
        end
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            pa_ext[5:4] <= {2{i[0]}};
            irqs();
            check(8'(na), 8'(i));
        end
        wr(`FPGIO_ADDR_IRQ_EN, 8'hEF);
        @(posedge clk);
        pb_ext[4] <= 1'b0;
        repeat (4) @(posedge clk);
        pb_ext[4] <= 1'b1;
        irqs();
        check(8'(nb), 8'h00);
        wr(`FPGIO_ADDR_PB_DIR, 8'h20);
        wr(`FPGIO_ADDR_PB_DATA, 8'h20);
        irqs();
        check(8'(nb), 8'h00);
        wr(`FPGIO_ADDR_IRQ_EN, 8'h00);
        // Clock enable low: the write must be ignored
        ce <= 1'b0;
        wr(`FPGIO_ADDR_PD_DIR, ~m);
        ce <= 1'b1;
        rd(`FPGIO_ADDR_PD_DIR, m);
        wr(`FPGIO_ADDR_MISC, 8'h03);
        ctl <= 12'hE3F;
        pa_ext[3] <= 1'b1;
        pc_ext[0] <= 1'b0;
        settle(4);
        rd(`FPGIO_ADDR_MISC, 8'h03);
        settle(0);
        check(pa_oe_n[0], 8'h00);
        v = pa_out[0];
        settle(1);
        check(pa_out[0], !v[0]);
        check({pc_oe_n, pc_out}, 6'b001_110);
        check(timer_external_clock_in, 8'h01);
        check(capture_input_one, pa_ext[4]);
        check({pa_oe_n[7:6], pa_out[7:6]}, 8'h03);
        check(serial_receive_in, 8'h00);
        @(posedge clk);
        ctl <= 12'h140;
        pa_ext[2:1] <= 2'b11;
        settle(4);
        check({pa_oe_n[2:1], i2c_scl_in, i2c_sda_in}, 8'h0A);
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            adc_sel <= i[3:0];
            settle(2);
            check(analog_switch_b, i < 8 ? 8'h01 << i : 8'h00);
            check(analog_switch_d, i inside {[8:11]} ? 4'h1 << (i - 8) : 4'h0);
        end
        arst_n <= 1'b0;
        settle(2);
        arst_n <= 1'b1;
        rd(`FPGIO_ADDR_PB_DIR, 8'h00);
        settle(3);
        print_verdict();
    end
endmodule // tb_fpgio_top
